/* src/rtc_pkg.sv */
// constants and types shared by the realm translation control register bank
package rtc_pkg;

  // ==========================================================================
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  typedef logic [DATA_W-1:0] rtc_word_t;
  typedef logic [ADDR_W-1:0] rtc_addr_t;
  localparam rtc_word_t WORD_ZERO = 32'h00000000;

  // ==========================================================================
  // register offsets inside the realm page
  localparam rtc_addr_t OFF_CONTROL = 12'h020;
  localparam rtc_addr_t OFF_ACK = 12'h024;
  localparam rtc_addr_t OFF_ATTR = 12'h028;
  localparam rtc_addr_t OFF_CTRL2 = 12'h02C;

  // ==========================================================================
  // enable and acknowledge bit positions
  localparam int NUM_EN = 4;
  localparam int BIT_GLOBAL = 0;
  localparam int BIT_PRQ = 1;
  localparam int BIT_FAULT = 2;
  localparam int BIT_CMD = 3;
  typedef logic [NUM_EN-1:0] rtc_en_t;
  localparam rtc_en_t EN_ZERO = 4'h0;
  localparam rtc_en_t EN_ALL = 4'hF;
  localparam rtc_en_t EN_PRQ_MASK = 4'h2;
  localparam rtc_en_t RING_EN_MASK = 4'hE;

  // ==========================================================================
  // memory attribute field layout
  localparam int FIELD_W = 2;
  localparam int ATTR_W = 12;
  localparam int POS_SSH = 10;
  localparam int POS_SOC = 8;
  localparam int POS_SIC = 6;
  localparam int POS_RSH = 4;
  localparam int POS_ROC = 2;
  localparam int POS_RIC = 0;
  typedef logic [ATTR_W-1:0] rtc_attr_t;
  localparam rtc_attr_t ATTR_RESET = 12'h000;

  // ==========================================================================
  // second control register
  localparam int CTRL2_W = 4;
  typedef logic [CTRL2_W-1:0] rtc_ctrl2_t;
  localparam rtc_ctrl2_t CTRL2_RESET = 4'h0;

  // ==========================================================================
  // attribute encodings
  typedef enum logic [1:0] {
    SH_NON = 2'h0,
    SH_RSVD = 2'h1,
    SH_OUTER = 2'h2,
    SH_INNER = 2'h3
  } rtc_share_t;
  typedef enum logic [1:0] {
    CA_NC = 2'h0,
    CA_WB = 2'h1,
    CA_WT = 2'h2,
    CA_RSVD = 2'h3
  } rtc_cache_t;
  localparam int HINT_W = 2;
  localparam int NUM_RINGS = 3;
  localparam logic [HINT_W-1:0] HINT_NONE = 2'h0;

  // ==========================================================================
  // enable transition timing
  localparam int TRANSITION_NS = 16;
  localparam int CLK_MHZ = 250;
  localparam int TRANSITION_CYCLES = (TRANSITION_NS * CLK_MHZ + 999) / 1000;

endpackage : rtc_pkg

/* src/rtc_ack_if.sv */
// enable request and acknowledge bundle between control and tracker
`timescale 1ns/1ps
`default_nettype none

interface rtc_ack_if;
  // requested enables from software, acknowledged copies from the tracker
  rtc_pkg::rtc_en_t enable_req;
  rtc_pkg::rtc_en_t enable_ack;
  modport ctrl (output enable_req, input enable_ack);
  modport trk (input enable_req, output enable_ack);
endinterface : rtc_ack_if

`default_nettype wire

/* src/rtc_ack_tracker.sv */
// per-enable transition timer that copies a settled enable into its ack
`timescale 1ns/1ps
`default_nettype none

module rtc_ack_tracker #(
  parameter int CYCLES = rtc_pkg::TRANSITION_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  rtc_ack_if.trk link
);

  localparam int CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // ==========================================================================
  // one timer per enable; a request that reverts early restarts the wait
  genvar g;
  generate
    for (g = 0; g < rtc_pkg::NUM_EN; g++) begin : g_track
      logic [CNT_W-1:0] count;
      logic ack;
      wire pending = link.enable_req[g] != ack;
      wire done = pending && (count == CNT_LAST);
      // ack only moves once the transition time has elapsed
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          count <= CNT_ZERO;
          ack <= 1'b0;
        end else if (done) begin
          count <= CNT_ZERO;
          ack <= link.enable_req[g];
        end else if (pending) begin
          count <= count + CNT_ONE;
        end else begin
          count <= CNT_ZERO;
        end
      end
      assign link.enable_ack[g] = ack;
    end
  endgenerate

endmodule : rtc_ack_tracker

`default_nettype wire

/* src/rtc_regs.sv */
// realm translation control register bank: enables, acks and attributes
//
// Overview of operation
// - page request ack bit reported when supported
// - global enable ack in bit 0, reset 0
// - acknowledge register at 0x24, read only
// - non realm non root access reads zero
// - structure shareability decode, reserved means non-shareable
// - structure non-cacheable forces outer shareable (here only when both raw codes are NC; reserved codes keep their share field)
// - structure outer cacheability decode, reserved non-cacheable
// - structure inner cacheability decode, reserved non-cacheable
// - structure fields locked unless global enable idle
// - ring shareability decode, reserved means non-shareable
// - ring non-cacheable forces outer shareable (here only when both raw codes are NC; reserved codes keep their share field)
// - ring outer cacheability decode, reserved non-cacheable
// - ring inner cacheability decode, reserved non-cacheable
// - ring fields locked unless all rings idle
// - attribute reset uses preset values when fixed
// - structure attrs for tables, ring attrs for queues
// - allocation hints dropped for non-cacheable memory
// - unsupported memory type aborts, fetch fault raised
// - attribute register at 0x28, read write
// - enable change acknowledged after its transition
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module rtc_regs #(
  parameter bit PRQ_SUPPORTED = 1'b1,
  parameter bit EXT_RINGS_PRESENT = 1'b0,
  parameter int NUM_EXT_RINGS = 1,
  parameter bit STRUCT_ATTRS_FIXED = 1'b0,
  parameter bit RING_ATTRS_FIXED = 1'b0,
  parameter rtc_pkg::rtc_attr_t ATTR_PRESET = rtc_pkg::ATTR_RESET,
  parameter bit WB_SUPPORTED = 1'b1,
  parameter bit WT_SUPPORTED = 1'b1
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire rtc_pkg::rtc_addr_t REG_ADDR,
  input wire rtc_pkg::rtc_word_t REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic ACCESS_REALM,
  input wire logic ACCESS_ROOT,
  output rtc_pkg::rtc_word_t REG_RDATA,
  input wire logic [NUM_EXT_RINGS-1:0] EXT_RING_ENABLE,
  input wire logic [NUM_EXT_RINGS-1:0] EXT_RING_ENABLE_ACK,
  input wire logic [rtc_pkg::HINT_W-1:0] STRUCT_ALLOC_HINT,
  input wire logic [rtc_pkg::NUM_RINGS*rtc_pkg::HINT_W-1:0] RING_ALLOC_HINT,
  input wire logic STRUCT_FETCH_REQ,
  output rtc_pkg::rtc_en_t ENABLE_ACK,
  output rtc_pkg::rtc_share_t STRUCT_SHARE,
  output rtc_pkg::rtc_cache_t STRUCT_OUTER,
  output rtc_pkg::rtc_cache_t STRUCT_INNER,
  output rtc_pkg::rtc_share_t RING_SHARE,
  output rtc_pkg::rtc_cache_t RING_OUTER,
  output rtc_pkg::rtc_cache_t RING_INNER,
  output logic [rtc_pkg::HINT_W-1:0] STRUCT_HINT_EFF,
  output logic [rtc_pkg::NUM_RINGS*rtc_pkg::HINT_W-1:0] RING_HINT_EFF,
  output logic STREAM_TABLE_FETCH_FAULT,
  output logic RING_ACCESS_ABORT
);

  // ==========================================================================
  // decode helpers, each used for both structure and ring fields
  function automatic rtc_pkg::rtc_cache_t cache_eff(
    input logic [rtc_pkg::FIELD_W-1:0] raw
  );
    rtc_pkg::rtc_cache_t c;
    c = rtc_pkg::rtc_cache_t'(raw);
    cache_eff = (c == rtc_pkg::CA_RSVD) ? rtc_pkg::CA_NC : c;
  endfunction : cache_eff

  function automatic rtc_pkg::rtc_share_t share_eff(
    input logic [rtc_pkg::FIELD_W-1:0] sh,
    input logic [rtc_pkg::FIELD_W-1:0] oc,
    input logic [rtc_pkg::FIELD_W-1:0] ic
  );
    rtc_pkg::rtc_share_t s;
    s = rtc_pkg::rtc_share_t'(sh);
    if (oc == rtc_pkg::CA_NC && ic == rtc_pkg::CA_NC) begin
      share_eff = rtc_pkg::SH_OUTER;
    end else if (s == rtc_pkg::SH_RSVD) begin
      share_eff = rtc_pkg::SH_NON;
    end else begin
      share_eff = s;
    end
  endfunction : share_eff

  function automatic logic type_unsupported(
    input rtc_pkg::rtc_cache_t c
  );
    type_unsupported = (c == rtc_pkg::CA_WB && !WB_SUPPORTED) ||
                       (c == rtc_pkg::CA_WT && !WT_SUPPORTED);
  endfunction : type_unsupported

  // one attribute field picked out of the stored word
  function automatic logic [rtc_pkg::FIELD_W-1:0] field_at(
    input rtc_pkg::rtc_attr_t word,
    input int pos
  );
    field_at = word[pos +: rtc_pkg::FIELD_W];
  endfunction : field_at

  // ==========================================================================
  // state
  // enables live here; the tracker only ever sees a copy of them
  rtc_pkg::rtc_en_t control_en;
  rtc_pkg::rtc_attr_t attr;
  rtc_pkg::rtc_ctrl2_t ctrl2;
  rtc_ack_if ack_link ();

  rtc_ack_tracker #(
    .CYCLES(rtc_pkg::TRANSITION_CYCLES)
  ) u_tracker (
    .clk(CORE_CLK),
    .reset_n(RESET_N),
    .link(ack_link.trk)
  );

  // requested enables start a transition in the tracker
  assign ack_link.enable_req = control_en;

  // ==========================================================================
  // access decode
  // permission is judged per strobe; a refused read still answers zero
  wire permitted = ACCESS_REALM | ACCESS_ROOT;
  wire wr_ok = REG_WR & permitted;
  wire rd_ok = REG_RD & permitted;
  wire hit_control = REG_ADDR == rtc_pkg::OFF_CONTROL;
  wire hit_ack = REG_ADDR == rtc_pkg::OFF_ACK;
  wire hit_attr = REG_ADDR == rtc_pkg::OFF_ATTR;
  wire hit_ctrl2 = REG_ADDR == rtc_pkg::OFF_CTRL2;

  // unsupported page requests keep that bit stuck at zero
  localparam rtc_pkg::rtc_en_t EN_IMPL =
    PRQ_SUPPORTED ? rtc_pkg::EN_ALL : ~rtc_pkg::EN_PRQ_MASK;
  wire rtc_pkg::rtc_en_t ack_view =
    ack_link.enable_ack & EN_IMPL;

  // ==========================================================================
  // field lock conditions
  // request and ack are both looked at, so a write that races an enable
  // which is still settling is refused rather than half applied
  // structure fields and the second control register follow the global pair
  wire struct_unlocked = !control_en[rtc_pkg::BIT_GLOBAL] &&
                         !ack_view[rtc_pkg::BIT_GLOBAL];
  // extended rings only count when they exist
  wire ext_idle = !EXT_RINGS_PRESENT ||
                  (!(|EXT_RING_ENABLE) && !(|EXT_RING_ENABLE_ACK));
  wire ring_unlocked = !(|(control_en & rtc_pkg::RING_EN_MASK)) &&
                       !(|(ack_view & rtc_pkg::RING_EN_MASK)) &&
                       ext_idle;

  // ==========================================================================
  // field group masks, built from the layout so a moved field follows
  localparam rtc_pkg::rtc_attr_t FIELD_ONES =
    rtc_pkg::rtc_attr_t'({rtc_pkg::FIELD_W{1'b1}});
  localparam rtc_pkg::rtc_attr_t STRUCT_MASK =
    (FIELD_ONES << rtc_pkg::POS_SSH) |
    (FIELD_ONES << rtc_pkg::POS_SOC) |
    (FIELD_ONES << rtc_pkg::POS_SIC);
  localparam rtc_pkg::rtc_attr_t RING_MASK =
    (FIELD_ONES << rtc_pkg::POS_RSH) |
    (FIELD_ONES << rtc_pkg::POS_ROC) |
    (FIELD_ONES << rtc_pkg::POS_RIC);
  localparam rtc_pkg::rtc_attr_t NO_BITS = '0;

  // ==========================================================================
  // next values for the writable registers
  // only the low attribute bits are stored, so reserved bits drop out
  wire rtc_pkg::rtc_attr_t wr_attr =
    REG_WDATA[rtc_pkg::ATTR_W-1:0];
  wire rtc_pkg::rtc_attr_t struct_mask = STRUCT_MASK;
  wire rtc_pkg::rtc_attr_t ring_mask = RING_MASK;
  wire rtc_pkg::rtc_attr_t write_mask =
    (struct_unlocked ? struct_mask : NO_BITS) |
    (ring_unlocked ? ring_mask : NO_BITS);
  wire attr_we = wr_ok && hit_attr;
  wire rtc_pkg::rtc_attr_t next_attr =
    attr_we ? ((wr_attr & write_mask) | (attr & ~write_mask)) : attr;

  wire control_we = wr_ok && hit_control;
  wire rtc_pkg::rtc_en_t next_control_en =
    control_we ? (REG_WDATA[rtc_pkg::NUM_EN-1:0] & EN_IMPL) : control_en;

  // a write landing mid-transition of the global enable is ignored
  wire ctrl2_we = wr_ok && hit_ctrl2 && struct_unlocked;
  wire rtc_pkg::rtc_ctrl2_t next_ctrl2 =
    ctrl2_we ? REG_WDATA[rtc_pkg::CTRL2_W-1:0] : ctrl2;

  // ==========================================================================
  // read mux; the ack register has no write path at all
  // unmapped offsets fall through to zero rather than aliasing
  wire rtc_pkg::rtc_word_t rd_value =
    hit_control ? rtc_pkg::rtc_word_t'(control_en) :
    hit_ack ? rtc_pkg::rtc_word_t'(ack_view) :
    hit_attr ? rtc_pkg::rtc_word_t'(attr) :
    hit_ctrl2 ? rtc_pkg::rtc_word_t'(ctrl2) :
    rtc_pkg::WORD_ZERO;
  wire rtc_pkg::rtc_word_t next_rdata =
    rd_ok ? rd_value : rtc_pkg::WORD_ZERO;

  // ==========================================================================
  // field extraction
  wire [rtc_pkg::FIELD_W-1:0] f_ssh = field_at(attr, rtc_pkg::POS_SSH);
  wire [rtc_pkg::FIELD_W-1:0] f_soc = field_at(attr, rtc_pkg::POS_SOC);
  wire [rtc_pkg::FIELD_W-1:0] f_sic = field_at(attr, rtc_pkg::POS_SIC);
  wire [rtc_pkg::FIELD_W-1:0] f_rsh = field_at(attr, rtc_pkg::POS_RSH);
  wire [rtc_pkg::FIELD_W-1:0] f_roc = field_at(attr, rtc_pkg::POS_ROC);
  wire [rtc_pkg::FIELD_W-1:0] f_ric = field_at(attr, rtc_pkg::POS_RIC);

  // ==========================================================================
  // effective attributes seen by the fetch logic
  wire rtc_pkg::rtc_cache_t s_outer = cache_eff(f_soc);
  wire rtc_pkg::rtc_cache_t s_inner = cache_eff(f_sic);
  wire rtc_pkg::rtc_share_t s_share =
    share_eff(f_ssh, f_soc, f_sic);
  wire rtc_pkg::rtc_cache_t r_outer = cache_eff(f_roc);
  wire rtc_pkg::rtc_cache_t r_inner = cache_eff(f_ric);
  wire rtc_pkg::rtc_share_t r_share =
    share_eff(f_rsh, f_roc, f_ric);

  // hints only mean something when some level caches the data
  wire s_cacheable = (s_outer != rtc_pkg::CA_NC) ||
                     (s_inner != rtc_pkg::CA_NC);
  wire r_cacheable = (r_outer != rtc_pkg::CA_NC) ||
                     (r_inner != rtc_pkg::CA_NC);
  wire [rtc_pkg::HINT_W-1:0] next_s_hint =
    s_cacheable ? STRUCT_ALLOC_HINT : rtc_pkg::HINT_NONE;
  wire [rtc_pkg::NUM_RINGS*rtc_pkg::HINT_W-1:0] next_r_hint =
    r_cacheable ? RING_ALLOC_HINT : '0;

  // memory types the fabric cannot serve are turned into aborts
  wire s_unsupported = type_unsupported(s_outer) || type_unsupported(s_inner);
  wire r_unsupported = type_unsupported(r_outer) || type_unsupported(r_inner);
  wire next_fetch_fault = STRUCT_FETCH_REQ && s_unsupported;

  // ==========================================================================
  // attribute reset value; when not fixed a defined zero stands in for unknown
  localparam rtc_pkg::rtc_attr_t STRUCT_RESET =
    STRUCT_ATTRS_FIXED ? ATTR_PRESET : rtc_pkg::ATTR_RESET;
  localparam rtc_pkg::rtc_attr_t RING_RESET =
    RING_ATTRS_FIXED ? ATTR_PRESET : rtc_pkg::ATTR_RESET;
  localparam rtc_pkg::rtc_attr_t ATTR_INIT =
    (STRUCT_RESET & STRUCT_MASK) | (RING_RESET & RING_MASK);

  // ==========================================================================
  // software visible registers, one short process each
  // enables come up clear so every internal ring starts idle and, with the extended rings idle, unlocked
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      control_en <= rtc_pkg::EN_ZERO;
    end else begin
      control_en <= next_control_en;
    end
  end

  // attribute word; locked fields are merged back in next_attr
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      attr <= ATTR_INIT;
    end else begin
      attr <= next_attr;
    end
  end

  // second control register, guarded by the global enable pair
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ctrl2 <= rtc_pkg::CTRL2_RESET;
    end else begin
      ctrl2 <= next_ctrl2;
    end
  end

  // read data stands for one cycle after the strobe, zero otherwise
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      REG_RDATA <= rtc_pkg::WORD_ZERO;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

  // ==========================================================================
  // registered outputs toward the table walker and queue engines
  // one extra flop keeps outputs clean at the cost of a cycle of latency
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ENABLE_ACK <= rtc_pkg::EN_ZERO;
    end else begin
      ENABLE_ACK <= ack_view;
    end
  end

  // structure fetch attributes
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      STRUCT_SHARE <= rtc_pkg::SH_NON;
      STRUCT_OUTER <= rtc_pkg::CA_NC;
      STRUCT_INNER <= rtc_pkg::CA_NC;
    end else begin
      STRUCT_SHARE <= s_share;
      STRUCT_OUTER <= s_outer;
      STRUCT_INNER <= s_inner;
    end
  end

  // ring access attributes
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      RING_SHARE <= rtc_pkg::SH_NON;
      RING_OUTER <= rtc_pkg::CA_NC;
      RING_INNER <= rtc_pkg::CA_NC;
    end else begin
      RING_SHARE <= r_share;
      RING_OUTER <= r_outer;
      RING_INNER <= r_inner;
    end
  end

  // allocation hints, cleared for non-cacheable memory
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      STRUCT_HINT_EFF <= rtc_pkg::HINT_NONE;
      RING_HINT_EFF <= '0;
    end else begin
      STRUCT_HINT_EFF <= next_s_hint;
      RING_HINT_EFF <= next_r_hint;
    end
  end

  // abort indications; the fetch fault follows STRUCT_FETCH_REQ one cycle later, for as long as it is held and the structure memory type is unsupported
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      STREAM_TABLE_FETCH_FAULT <= 1'b0;
      RING_ACCESS_ABORT <= 1'b0;
    end else begin
      STREAM_TABLE_FETCH_FAULT <= next_fetch_fault;
      RING_ACCESS_ABORT <= r_unsupported;
    end
  end

endmodule : rtc_regs

`default_nettype wire

/* sim/rtc_regs_properties.sv */
// port-level assertions for the realm translation control register bank
`timescale 1ns/1ps
`default_nettype none

module rtc_regs_properties (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire rtc_pkg::rtc_addr_t REG_ADDR,
  input wire logic REG_RD,
  input wire logic ACCESS_REALM,
  input wire logic ACCESS_ROOT,
  input wire rtc_pkg::rtc_word_t REG_RDATA,
  input wire logic STRUCT_FETCH_REQ,
  input wire rtc_pkg::rtc_en_t ENABLE_ACK,
  input wire rtc_pkg::rtc_share_t STRUCT_SHARE,
  input wire rtc_pkg::rtc_cache_t STRUCT_OUTER,
  input wire rtc_pkg::rtc_cache_t STRUCT_INNER,
  input wire rtc_pkg::rtc_share_t RING_SHARE,
  input wire rtc_pkg::rtc_cache_t RING_OUTER,
  input wire rtc_pkg::rtc_cache_t RING_INNER,
  input wire logic [1:0] STRUCT_HINT_EFF,
  input wire logic [5:0] RING_HINT_EFF,
  input wire logic STREAM_TABLE_FETCH_FAULT
);
  // ==========================================================================
  // access qualification
  wire logic acc_ok;
  wire logic rd_ok;
  assign acc_ok = ACCESS_REALM | ACCESS_ROOT;
  assign rd_ok = REG_RD & acc_ok;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  // ==========================================================================
  // read port
  rd_idle_zero_a: assert property (!REG_RD |=> REG_RDATA == 32'h00000000)
    else $error("read data not zero outside a read");
  raz_read_a: assert property (REG_RD && !acc_ok |=> REG_RDATA == 32'h00000000)
    else $error("disallowed read returned data");
  ack_read_a: assert property (rd_ok && REG_ADDR == rtc_pkg::OFF_ACK
    |=> REG_RDATA == {28'h0000000, ENABLE_ACK}) else $error("ack readback wrong");
  attr_rsvd_a: assert property (rd_ok && REG_ADDR == rtc_pkg::OFF_ATTR
    |=> REG_RDATA[31:12] == 20'h00000) else $error("attr reserved bits set");

  // ==========================================================================
  // decoded attributes never show a reserved code
  share_codes_a: assert property (STRUCT_SHARE != rtc_pkg::SH_RSVD
    && RING_SHARE != rtc_pkg::SH_RSVD) else $error("reserved share code out");
  cache_codes_a: assert property (
    STRUCT_OUTER != rtc_pkg::CA_RSVD && STRUCT_INNER != rtc_pkg::CA_RSVD &&
    RING_OUTER != rtc_pkg::CA_RSVD && RING_INNER != rtc_pkg::CA_RSVD)
    else $error("reserved cache code out");

  // ==========================================================================
  // hints, locks and fetch fault
  struct_hint_a: assert property (STRUCT_OUTER == rtc_pkg::CA_NC &&
    STRUCT_INNER == rtc_pkg::CA_NC |-> STRUCT_HINT_EFF == 2'h0)
    else $error("structure hint kept for non-cacheable");
  ring_hint_a: assert property (RING_OUTER == rtc_pkg::CA_NC &&
    RING_INNER == rtc_pkg::CA_NC |-> RING_HINT_EFF == 6'h00)
    else $error("ring hint kept for non-cacheable");
  // a settled ack one cycle old means no write could have landed
  struct_lock_a: assert property (ENABLE_ACK[0] && $past(ENABLE_ACK[0])
    |-> $stable({STRUCT_SHARE, STRUCT_OUTER, STRUCT_INNER}))
    else $error("structure attrs changed while enabled");
  ring_lock_a: assert property (|ENABLE_ACK[3:1] && $past(|ENABLE_ACK[3:1])
    |-> $stable({RING_SHARE, RING_OUTER, RING_INNER}))
    else $error("ring attrs changed while rings enabled");
  fault_cause_a: assert property (STREAM_TABLE_FETCH_FAULT |-> $past(STRUCT_FETCH_REQ))
    else $error("fetch fault without a fetch");
endmodule : rtc_regs_properties

`default_nettype wire

/* sim/rtc_regs_test.sv */
// self-checking bench for the realm translation control register bank
`timescale 1ns/1ps
`default_nettype none

module rtc_regs_test;
  logic CORE_CLK = 1'b0;
  logic RESET_N = 1'b0;
  rtc_pkg::rtc_addr_t REG_ADDR = 12'h000;
  rtc_pkg::rtc_word_t REG_WDATA = 32'h00000000;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic ACCESS_REALM = 1'b0;
  logic ACCESS_ROOT = 1'b0;
  logic [0:0] EXT_RING_ENABLE = 1'b0;
  logic [0:0] EXT_RING_ENABLE_ACK = 1'b0;
  logic STRUCT_FETCH_REQ = 1'b0;
  rtc_pkg::rtc_word_t REG_RDATA;
  rtc_pkg::rtc_en_t ENABLE_ACK;
  rtc_pkg::rtc_share_t STRUCT_SHARE, RING_SHARE;
  rtc_pkg::rtc_cache_t STRUCT_OUTER, STRUCT_INNER, RING_OUTER, RING_INNER;
  logic [1:0] STRUCT_HINT_EFF;
  logic [5:0] RING_HINT_EFF;
  logic STREAM_TABLE_FETCH_FAULT, RING_ACCESS_ABORT;
  int bad_count = 0;
  int checks_done = 0;
  logic [11:0] m;
  logic [5:0] g, got, hg;
  logic [1:0] eo, ei, es;
  logic wt;
  logic [3:0] en;
  logic [11:0] rows [7] = '{12'h000, 12'h555, 12'hAAA, 12'hFFF, 12'hC30,
    12'h9A6, 12'h464};

  // write-through unsupported so the abort paths can be reached
  rtc_regs #(.EXT_RINGS_PRESENT(1'b1), .WT_SUPPORTED(1'b0)) dut_u (
    .CORE_CLK, .RESET_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
    .ACCESS_REALM, .ACCESS_ROOT, .REG_RDATA, .EXT_RING_ENABLE,
    .EXT_RING_ENABLE_ACK, .STRUCT_ALLOC_HINT(2'h3), .RING_ALLOC_HINT(6'h39),
    .STRUCT_FETCH_REQ, .ENABLE_ACK, .STRUCT_SHARE, .STRUCT_OUTER,
    .STRUCT_INNER, .RING_SHARE, .RING_OUTER, .RING_INNER, .STRUCT_HINT_EFF,
    .RING_HINT_EFF, .STREAM_TABLE_FETCH_FAULT, .RING_ACCESS_ABORT);

  // ==========================================================================
  // clock, watchdog and verdict
  initial forever #2 CORE_CLK = ~CORE_CLK;

  // the whole run is about two hundred cycles; the 10000-cycle limit means a hang
  initial begin
    #40000;
    bad_count++;
    end_sim();
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // ==========================================================================
  // bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  // one strobe cycle; who is {root, realm}; returns just after the take edge
  task automatic xfer(input bit w, input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] who);
    @(posedge CORE_CLK);
    REG_WR <= w;
    REG_RD <= !w;
    REG_ADDR <= a;
    REG_WDATA <= d;
    {ACCESS_ROOT, ACCESS_REALM} <= who;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
    #1;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 2'b01);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 2'b01);
    chk(REG_RDATA, e);
  endtask : rd

  // acks settle a few cycles after the enable; bounded wait
  task automatic wack(input logic [3:0] e);
    int n;
    n = 0;
    while (ENABLE_ACK !== e && n < 20) begin
      @(posedge CORE_CLK);
      #1;
      n++;
    end
    chk(ENABLE_ACK, e);
  endtask : wack

  // try to flip every attribute bit; locked halves must hold
  task automatic lock(input logic sl, input logic rl);
    wr(12'h028, {20'h0, ~m});
    if (!sl) m[11:6] = ~m[11:6];
    if (!rl) m[5:0] = ~m[5:0];
    rd(12'h028, {20'h0, m});
  endtask : lock

  // ==========================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    #1;
    chk({STRUCT_SHARE, RING_SHARE}, 4'hA);
    rd(12'h024, 32'h0);
    rd(12'h028, 32'h0);
    wr(12'h02C, 32'hFFFFFFFF);
    rd(12'h02C, 32'hF);
    // decode table, fault, abort and hints for each row
    foreach (rows[i]) begin
      m = rows[i];
      wr(12'h028, {20'hFFFFF, m});
      rd(12'h028, {20'h0, m});
      for (int k = 0; k < 2; k++) begin
        g = k ? m[5:0] : m[11:6];
        eo = g[3:2] == 2'h3 ? 2'h0 : g[3:2];
        ei = g[1:0] == 2'h3 ? 2'h0 : g[1:0];
        es = g[3:0] == 4'h0 ? 2'h2 : (g[5:4] == 2'h1 ? 2'h0 : g[5:4]);
        wt = eo == 2'h2 || ei == 2'h2;
        got = k ? {RING_SHARE, RING_OUTER, RING_INNER}
          : {STRUCT_SHARE, STRUCT_OUTER, STRUCT_INNER};
        hg = k ? RING_HINT_EFF : {4'h0, STRUCT_HINT_EFF};
        chk(got, {es, eo, ei});
        chk(hg, (eo != 0 || ei != 0) ? (k ? 6'h39 : 6'h03) : 6'h0);
        if (k) chk(RING_ACCESS_ABORT, wt);
        if (k == 0) begin
          @(posedge CORE_CLK);
          STRUCT_FETCH_REQ <= 1'b1;
          @(posedge CORE_CLK);
          STRUCT_FETCH_REQ <= 1'b0;
          #1;
          chk(STREAM_TABLE_FETCH_FAULT, wt);
        end
      end
    end
    // accesses that are neither realm nor root, then root alone
    xfer(1'b1, 12'h028, 32'h0, 2'b00);
    xfer(1'b0, 12'h028, 32'h0, 2'b00);
    chk(REG_RDATA, 32'h0);
    xfer(1'b1, 12'h024, 32'hF, 2'b10);
    xfer(1'b0, 12'h028, 32'h0, 2'b10);
    chk(REG_RDATA, {20'h0, m});
    rd(12'h024, 32'h0);
    rd(12'h100, 32'h0);
    // each enable in turn, then extended ring enable and its ack
    for (int i = 0; i < 6; i++) begin
      en = i < 4 ? 4'h1 << i : 4'h0;
      // extended ring pair changes on an edge, never twice in one step
      @(posedge CORE_CLK);
      {EXT_RING_ENABLE_ACK, EXT_RING_ENABLE} <=
        i < 4 ? 2'b00 : (i == 4 ? 2'b01 : 2'b10);
      wr(12'h020, {28'h0, en});
      chk(ENABLE_ACK, 4'h0);
      lock(en[0], |en[3:1] || i >= 4);
      wack(en);
      rd(12'h024, {28'h0, en});
      wr(12'h020, 32'h0);
      lock(en[0], |en[3:1] || i >= 4);
      wack(4'h0);
    end
    @(posedge CORE_CLK);
    {EXT_RING_ENABLE_ACK, EXT_RING_ENABLE} <= 2'b00;
    lock(1'b0, 1'b0);
    end_sim();
  end
endmodule : rtc_regs_test

bind rtc_regs rtc_regs_properties chk_u (.CORE_CLK, .RESET_N, .REG_ADDR,
  .REG_RD, .ACCESS_REALM, .ACCESS_ROOT, .REG_RDATA, .STRUCT_FETCH_REQ,
  .ENABLE_ACK, .STRUCT_SHARE, .STRUCT_OUTER, .STRUCT_INNER, .RING_SHARE,
  .RING_OUTER, .RING_INNER, .STRUCT_HINT_EFF, .RING_HINT_EFF,
  .STREAM_TABLE_FETCH_FAULT);

`default_nettype wire
